// ### design/adc_ser_out.sv
// Serial output, pattern, power and clock monitor control of a four-lane converter
//
// Behaviour
// - All channels sampled on one common edge
// - Twelve bits per lane per sample clock
// - LSB first by default, MSB optional
// - Bit clock at six times sample rate
// - Deskew sends alternating zero one bits
// - Frame clock marks first bit of word
// - Sync sends six zeros then six ones
// - User custom pattern replaces conversion data
// - Four drive settings, default 3.5mA
// - Power-down pin stops all channels, clocks
// - Each channel may power down alone
// - Slow or stopped sample clock forces power-down
// - Register option blocks stopped-clock power-down; flag still reported
// - Reset pulse clears all settings to zero
// - Twelve-times serial clock from internal PLL
// - Clocks and data share serializer path
// - Results delayed six samples and one bit
`timescale 1ns/1ps
module adc_ser_out #(
    parameter int LATENCY    = adc_ser_pkg::LATENCY_FRAMES,
    parameter int MON_COUNT  = adc_ser_pkg::MON_CYCLES
) (
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    input  wire logic                     ser_clk,
    input  wire logic                     sample_clock_in,
    input  wire logic                     power_down_pin,
    input  wire logic                     reset_pulse_pin,
    input  wire logic                     cfg_wr,
    input  wire adc_ser_pkg::cfg_t        cfg_in,
    input  wire adc_ser_pkg::chan_words_t conv_data,
    output logic [adc_ser_pkg::CHANNELS-1:0] lane_out,
    output logic                          bit_clock_out,
    output logic                          frame_clock_out,
    output logic [1:0]                    drive_sel_out,
    output logic [adc_ser_pkg::CHANNELS-1:0] chan_on_out,
    output logic                          powered_down,
    output logic                          clock_stopped,
    output logic                          cfg_busy
);

    // One serial bit of a lane for a given bit position
    function automatic logic lane_bit(
        input adc_ser_pkg::cfg_t  c,
        input adc_ser_pkg::word_t w,
        input logic [3:0]         idx
    );
        adc_ser_pkg::word_t pick;
        pick = c.custom ? c.custom_pattern : w;
        if (c.deskew) begin
            lane_bit = idx[0];
        end else if (c.sync) begin
            lane_bit = (idx >= adc_ser_pkg::FRAME_HALF);
        end else if (c.msb_first) begin
            lane_bit = pick[adc_ser_pkg::FRAME_LAST - idx];
        end else begin
            lane_bit = pick[idx];
        end
    endfunction : lane_bit

    // Last bit position of a frame; counter, pipeline and word load key off it
    function automatic logic frame_end(
        input logic [3:0] pos
    );
        frame_end = (pos == adc_ser_pkg::FRAME_LAST);
    endfunction : frame_end

    // Power state decode shared by status outputs and link control
    function automatic logic is_down(
        input adc_ser_pkg::pwr_state_t s
    );
        is_down = (s == adc_ser_pkg::PWR_DOWN);
    endfunction : is_down

    // ---------------- System clock domain ----------------

    logic                     pd_pin_level;
    logic                     reset_pulse_level;
    logic                     sample_level;
    logic                     sample_level_d;
    logic [adc_ser_pkg::MON_BITS-1:0] mon_count;
    adc_ser_pkg::cfg_t        cfg;
    adc_ser_pkg::pwr_state_t  pwr_state;
    logic                     pd_req;
    adc_ser_pkg::link_ctl_t   ctl_now;
    adc_ser_pkg::link_ctl_t   ctl_hold;
    logic                     req_toggle;
    logic                     ack_meta;
    logic                     ack_sync;
    logic                     link_ack;

    pin_filter #(
        .RESET_LEVEL (1'b0)
    ) u_pd_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (power_down_pin),
        .level   (pd_pin_level)
    );

    pin_filter #(
        .RESET_LEVEL (1'b0)
    ) u_reset_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (reset_pulse_pin),
        .level   (reset_pulse_level)
    );

    pin_filter #(
        .RESET_LEVEL (1'b0)
    ) u_sample_filter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (sample_clock_in),
        .level   (sample_level)
    );

    // Settings register; the reset pulse outranks a write in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst || reset_pulse_level) begin
            cfg <= adc_ser_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= cfg_in;
        end
    end

    // Previous filtered level, reset to the idle level of the pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_level_d <= 1'b0;
        end else begin
            sample_level_d <= sample_level;
        end
    end

    // Counts cycles since the last level change of the sample clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mon_count <= '0;
        end else if (sample_level != sample_level_d) begin
            mon_count <= '0;
        end else if (mon_count < adc_ser_pkg::MON_BITS'(MON_COUNT)) begin
            mon_count <= mon_count + 1'b1;
        end
    end

    // Coarse on purpose: a fast sample clock is only seen aliased here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clock_stopped <= 1'b0;
        end else if (sample_level != sample_level_d) begin
            clock_stopped <= 1'b0;
        end else if (mon_count >= adc_ser_pkg::MON_BITS'(MON_COUNT)) begin
            clock_stopped <= 1'b1;
        end
    end

    assign pd_req = pd_pin_level || (clock_stopped && !cfg.monitor_off);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_state <= adc_ser_pkg::PWR_RUN;
        end else begin
            case (pwr_state)
                adc_ser_pkg::PWR_RUN: begin
                    if (pd_req) begin
                        pwr_state <= adc_ser_pkg::PWR_DOWN;
                    end
                end
                adc_ser_pkg::PWR_DOWN: begin
                    if (!pd_req) begin
                        pwr_state <= adc_ser_pkg::PWR_RUN;
                    end
                end
                default: begin
                    pwr_state <= adc_ser_pkg::PWR_DOWN;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powered_down <= 1'b0;
        end else begin
            powered_down <= is_down(pwr_state);
        end
    end

    // Drive code is only reported; the output stage itself is analog
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            drive_sel_out <= adc_ser_pkg::DRIVE_DEFAULT;
        end else begin
            drive_sel_out <= cfg.drive_sel;
        end
    end

    // A powered-down device reports every channel off
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chan_on_out <= '0;
        end else if (is_down(pwr_state)) begin
            chan_on_out <= '0;
        end else begin
            chan_on_out <= ~cfg.chan_pd;
        end
    end

    assign ctl_now = '{cfg: cfg, pd: is_down(pwr_state)};

    // Toggle handshake; hold stays still while a transfer is in flight
    always_ff @(posedge clk) begin
        ack_meta <= link_ack;
        ack_sync <= ack_meta;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_busy <= 1'b0;
        end else begin
            cfg_busy <= (req_toggle != ack_sync) || (ctl_now != ctl_hold);
        end
    end

    // Hold reloads only once the previous transfer is acknowledged
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctl_hold   <= adc_ser_pkg::LINK_CTL_RESET;
            req_toggle <= 1'b0;
        end else if ((req_toggle == ack_sync) && (ctl_now != ctl_hold)) begin
            ctl_hold   <= ctl_now;
            req_toggle <= ~req_toggle;
        end
    end

    // ---------------- Serial clock domain ----------------
    // The twelve-times clock comes from the PLL and runs freely

    logic                       rst_meta;
    logic                       link_rst;
    logic                       req_meta;
    logic                       req_sync;
    adc_ser_pkg::link_ctl_t     lctl;
    logic [3:0]                 idx;
    adc_ser_pkg::chan_words_t   pipe [LATENCY];
    adc_ser_pkg::chan_words_t   frame_word;

    // Reset reaches the link through two flops of its own clock
    always_ff @(posedge ser_clk) begin
        rst_meta <= sys_rst;
        link_rst <= rst_meta;
    end

    always_ff @(posedge ser_clk) begin
        req_meta <= req_toggle;
        req_sync <= req_meta;
    end

    // Link copy of the settings, loaded only when a new toggle arrives
    always_ff @(posedge ser_clk) begin
        if (link_rst) begin
            lctl <= adc_ser_pkg::LINK_CTL_RESET;
        end else if (req_sync != link_ack) begin
            lctl <= ctl_hold;
        end
    end

    always_ff @(posedge ser_clk) begin
        if (link_rst) begin
            link_ack <= 1'b0;
        end else begin
            link_ack <= req_sync;
        end
    end

    // Bit position within a word; a frame is one sample period
    always_ff @(posedge ser_clk) begin
        if (link_rst || lctl.pd) begin
            idx <= '0;
        end else if (frame_end(idx)) begin
            idx <= '0;
        end else begin
            idx <= idx + 1'b1;
        end
    end

    // All four words enter on the same edge so channels stay matched
    always_ff @(posedge ser_clk) begin
        if (frame_end(idx)) begin
            pipe[0] <= conv_data;
            for (int i = 1; i < LATENCY; i++) begin
                pipe[i] <= pipe[i-1];
            end
        end
    end

    always_ff @(posedge ser_clk) begin
        if (link_rst) begin
            frame_word <= '0;
        end else if (frame_end(idx)) begin
            frame_word <= pipe[LATENCY-1];
        end
    end

    // Clocks and data leave from one register stage so they stay aligned
    always_ff @(posedge ser_clk) begin
        if (link_rst || lctl.pd) begin
            bit_clock_out   <= 1'b0;
            frame_clock_out <= 1'b0;
        end else begin
            bit_clock_out   <= ~idx[0];
            frame_clock_out <= (idx < adc_ser_pkg::FRAME_HALF);
        end
    end

    // Same stage as the clocks above; a parked lane stays low
    always_ff @(posedge ser_clk) begin
        if (link_rst || lctl.pd) begin
            lane_out <= '0;
        end else begin
            for (int c = 0; c < adc_ser_pkg::CHANNELS; c++) begin
                if (lctl.cfg.chan_pd[c]) begin
                    lane_out[c] <= 1'b0;
                end else begin
                    lane_out[c] <= lane_bit(lctl.cfg, frame_word[c], idx);
                end
            end
        end
    end

endmodule : adc_ser_out

// ### design/adc_ser_pkg.sv
// Shared constants and types for the quad converter serial output block
package adc_ser_pkg;

    localparam int CHANNELS       = 4;
    localparam int WORD_BITS      = 12;
    localparam int IDX_BITS       = 4;
    localparam logic [3:0] FRAME_LAST = 4'hb;
    localparam logic [3:0] FRAME_HALF = 4'h6;
    localparam int LATENCY_FRAMES = 6;

    // System clock and stopped-clock threshold
    localparam int CLK_PERIOD_NS  = 20;
    localparam int MON_LIMIT_NS   = 333;
    localparam int MON_CYCLES     = MON_LIMIT_NS / CLK_PERIOD_NS;
    localparam int MON_BITS       = 5;

    // Drive current codes; zero is the default setting
    localparam logic [1:0] DRIVE_DEFAULT = 2'h0;

    typedef logic [WORD_BITS-1:0] word_t;
    typedef word_t [CHANNELS-1:0] chan_words_t;

    typedef struct packed {
        logic                msb_first;
        logic                deskew;
        logic                sync;
        logic                custom;
        word_t               custom_pattern;
        logic [1:0]          drive_sel;
        logic [CHANNELS-1:0] chan_pd;
        logic                monitor_off;
    } cfg_t;

    localparam cfg_t CFG_RESET = '0;

    typedef struct packed {
        cfg_t cfg;
        logic pd;
    } link_ctl_t;

    localparam link_ctl_t LINK_CTL_RESET = '{cfg: '0, pd: 1'b1};

    typedef enum logic [1:0] {
        PWR_RUN  = 2'b01,
        PWR_DOWN = 2'b10
    } pwr_state_t;

endpackage : adc_ser_pkg

// ### design/pin_filter.sv
// Three-flop pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ps
module pin_filter #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk) begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
    end

    // A single disagreeing sample is treated as a glitch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level <= RESET_LEVEL;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end

endmodule : pin_filter

// ### verification/adc_ser_out_monitor.sv
// Port-level assertions for the serial output block
`timescale 1ns/1ps
module adc_ser_out_monitor #(
    parameter int MON_COUNT = adc_ser_pkg::MON_CYCLES
) (
    input wire logic                             clk,
    input wire logic                             sys_rst,
    input wire logic                             ser_clk,
    input wire logic                             sample_clock_in,
    input wire logic                             power_down_pin,
    input wire logic                             reset_pulse_pin,
    input wire logic                             cfg_wr,
    input wire adc_ser_pkg::cfg_t                cfg_in,
    input wire logic                             bit_clock_out,
    input wire logic                             frame_clock_out,
    input wire logic [1:0]                       drive_sel_out,
    input wire logic [adc_ser_pkg::CHANNELS-1:0] chan_on_out,
    input wire logic                             powered_down,
    input wire logic                             clock_stopped
);
    logic prev;
    int   still;
    // Raw pin count, margin covers the input filter
    always_ff @(posedge clk) begin
        prev  <= sample_clock_in;
        still <= (sys_rst || sample_clock_in != prev) ? 0 : still + 1;
    end
    sequence s_frame_hi; frame_clock_out [*6] ##1 !frame_clock_out; endsequence
    sequence s_quiet_wr; !reset_pulse_pin [*5] ##0 cfg_wr; endsequence
    property p_bclk; @(posedge ser_clk) disable iff (sys_rst)
        $rose(frame_clock_out) |-> bit_clock_out ##1 !bit_clock_out ##1 bit_clock_out; endproperty
    property p_frame; @(posedge ser_clk) disable iff (sys_rst || powered_down)
        $rose(frame_clock_out) |-> s_frame_hi; endproperty
    property p_drive; @(posedge clk) disable iff (sys_rst)
        s_quiet_wr |-> ##2 drive_sel_out == $past(cfg_in.drive_sel, 2); endproperty
    property p_chan; @(posedge clk) disable iff (sys_rst)
        s_quiet_wr |-> ##2 (powered_down || chan_on_out == ~$past(cfg_in.chan_pd, 2)); endproperty
    property p_pin_pd; @(posedge clk) disable iff (sys_rst)
        power_down_pin [*8] |-> powered_down && chan_on_out == '0; endproperty
    property p_mon_set; @(posedge clk) disable iff (sys_rst) still >= MON_COUNT + 8 |-> clock_stopped; endproperty
    property p_mon_clr; @(posedge clk) disable iff (sys_rst)
        $changed(sample_clock_in) ##1 $stable(sample_clock_in) |-> ##[0:5] !clock_stopped; endproperty
    property p_clear; @(posedge clk) disable iff (sys_rst)
        reset_pulse_pin [*7] |-> drive_sel_out == 2'h0; endproperty
    a_bclk: assert property (p_bclk) else $error("bit clock out of step");
    a_frame: assert property (p_frame) else $error("frame clock not six high");
    a_drive: assert property (p_drive) else $error("drive code not applied");
    a_chan: assert property (p_chan) else $error("channel enable wrong");
    a_pin_pd: assert property (p_pin_pd) else $error("pin did not power down");
    a_mon_set: assert property (p_mon_set) else $error("stopped clock missed");
    a_mon_clr: assert property (p_mon_clr) else $error("stopped flag stuck");
    a_clear: assert property (p_clear) else $error("settings not cleared");
endmodule : adc_ser_out_monitor

bind adc_ser_out adc_ser_out_monitor #(.MON_COUNT(MON_COUNT)) mon (.clk, .sys_rst, .ser_clk, .sample_clock_in,
    .power_down_pin, .reset_pulse_pin, .cfg_wr, .cfg_in, .bit_clock_out, .frame_clock_out, .drive_sel_out,
    .chan_on_out, .powered_down, .clock_stopped);

// ### verification/lane_rx.sv
// Receiver model that gathers each lane into words
`timescale 1ns/1ps
module lane_rx (
    input  wire logic                     ser_clk,
    input  wire logic [3:0]               lane,
    input  wire logic                     frame,
    output adc_ser_pkg::chan_words_t      words,
    output int                            frames = 0
);
    adc_ser_pkg::chan_words_t acc;
    int                       k = 12;
    logic                     fq = 1'b0;
    // Mid-bit capture, as the bit clock is edge aligned
    always @(negedge ser_clk) begin
        k = (frame && !fq) ? 0 : k + 1;
        fq = frame;
        for (int c = 0; c < 4; c++) if (k < 12) acc[c][k] = lane[c];
        if (k == 11) begin
            words  <= acc;
            frames <= frames + 1;
        end
    end
endmodule : lane_rx

// ### verification/quad_adc_serial_output_ctrl_test.sv
// Bench for the quad converter serial output block
`timescale 1ns/1ps
module quad_adc_serial_output_ctrl_test;
    logic clk = 1'b0, ser_clk = 1'b0, sys_rst = 1'b1, sample_clock_in = 1'b0, power_down_pin = 1'b0;
    logic reset_pulse_pin = 1'b0, cfg_wr = 1'b0, run_sc = 1'b1, sc_div = 1'b0;
    adc_ser_pkg::cfg_t        cfg_in = '0, c;
    adc_ser_pkg::chan_words_t conv_data = '0, words;
    logic [3:0]               lane_out, chan_on_out;
    logic [1:0]               drive_sel_out;
    logic                     bit_clock_out, frame_clock_out, powered_down, clock_stopped, cfg_busy;
    logic [31:0]              seed = 32'h244722bd;
    int                       failures = 0, checks = 0, frames, f0;

    always #10 clk = ~clk;
    initial begin
        #7;
        forever #32 ser_clk = ~ser_clk;
    end
    always @(posedge clk) begin
        sc_div <= ~sc_div;
        if (run_sc && sc_div) sample_clock_in <= ~sample_clock_in;
    end

    adc_ser_out #(.LATENCY(2)) uut (.clk, .sys_rst, .ser_clk, .sample_clock_in, .power_down_pin, .reset_pulse_pin,
        .cfg_wr, .cfg_in, .conv_data, .lane_out, .bit_clock_out, .frame_clock_out, .drive_sel_out, .chan_on_out,
        .powered_down, .clock_stopped, .cfg_busy);
    lane_rx rx (.ser_clk, .lane(lane_out), .frame(frame_clock_out), .words, .frames);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic adc_ser_pkg::word_t exp_word(adc_ser_pkg::cfg_t k, adc_ser_pkg::word_t w, int ch);
        adc_ser_pkg::word_t v;
        v = k.custom ? k.custom_pattern : w;
        if (k.msb_first) v = {<<{v}};
        if (k.sync) v = 12'hfc0;
        if (k.deskew) v = 12'haaa;
        return k.chan_pd[ch] ? 12'h000 : v;
    endfunction : exp_word
    task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_state(input logic [3:0] got, input logic [3:0] exp);
        cmp_word({8'h00, got}, {8'h00, exp});
    endtask : cmp_state
    task automatic wcfg(input adc_ser_pkg::cfg_t k);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_in <= k;
        @(posedge clk);
        cfg_wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        for (int n = 0; n < 300 && cfg_busy !== 1'b0; n++) #20;
        cmp_state({3'h0, cfg_busy}, 4'h0);
        repeat (60) @(posedge ser_clk);
    endtask : wcfg
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        // Corners first: plain data, all patterns, sync over custom, reversed custom
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            c = adc_ser_pkg::cfg_t'(seed[22:0]);
            if (i < 4) {c.msb_first, c.deskew, c.sync, c.custom} = 4'(16'h9370 >> (4 * i));
            @(posedge ser_clk);
            for (int ch = 0; ch < 4; ch++) conv_data[ch] <= seed[ch*5 +: 12];
            wcfg(c);
            for (int ch = 0; ch < 4; ch++) cmp_word(words[ch], exp_word(c, conv_data[ch], ch));
            cmp_state({2'h0, drive_sel_out}, {2'h0, c.drive_sel});
            cmp_state(chan_on_out, ~c.chan_pd);
            $display("pattern test %0d ended", i);
        end
        f0 = frames;
        repeat (120) @(posedge ser_clk);
        cmp_word(12'(frames - f0), 12'h00a);
        power_down_pin <= 1'b1;
        // Long enough for a frame cut by power-down to finish in the receiver
        repeat (60) @(posedge clk);
        f0 = frames;
        repeat (48) @(posedge ser_clk);
        cmp_state({3'h0, powered_down}, 4'h1);
        cmp_word(12'(frames - f0), 12'h000);
        power_down_pin <= 1'b0;
        c = '0;
        wcfg(c);
        cmp_state({3'h0, powered_down}, 4'h0);
        $display("power pin test ended");
        @(posedge clk);
        run_sc <= 1'b0;
        repeat (60) @(posedge clk);
        cmp_state({2'h0, clock_stopped, powered_down}, 4'h3);
        c.monitor_off = 1'b1;
        wcfg(c);
        cmp_state({3'h0, powered_down}, 4'h0);
        run_sc <= 1'b1;
        repeat (20) @(posedge clk);
        cmp_state({3'h0, clock_stopped}, 4'h0);
        $display("clock monitor test ended");
        c.drive_sel = 2'h3;
        c.chan_pd = 4'h5;
        wcfg(c);
        reset_pulse_pin <= 1'b1;
        repeat (6) @(posedge clk);
        // Write during the clear must be lost
        wcfg(c);
        cmp_state({2'h0, drive_sel_out}, 4'h0);
        cmp_state(chan_on_out, 4'hf);
        reset_pulse_pin <= 1'b0;
        $display("reset pulse test ended");
        report_and_stop();
    end
endmodule : quad_adc_serial_output_ctrl_test
